/* design/rsc_pkg.sv */
package rsc_pkg;
  // stack geometry
  localparam int STK_W = 15;
  localparam int STK_D = 16;
  localparam int SP_W = 5;
  localparam int SA_W = 4;
  localparam logic [SP_W-1:0] SP_FULL = 5'h10;
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
  localparam logic [SP_W-1:0] SP_ONE = 5'h01;

  // configuration word addresses and erased value
  localparam int CFG_AW = 16;
  localparam int CFG_DW = 14;
  localparam logic [CFG_AW-1:0] CFG_SUP_ADDR = 16'h8008;
  localparam logic [CFG_AW-1:0] CFG_WDT_ADDR = 16'h8009;
  localparam logic [CFG_DW-1:0] CFG_RST_VAL = 14'h3fff;

  // supervisor_config_word fields
  localparam int SUP_XCLR_EN = 0;
  localparam int SUP_POWERUP_DELAY_SELECT_LO = 1;
  localparam int SUP_STK_RST = 12;
  // watchdog_config_word fields
  localparam int WDT_CPS_LO = 0;
  localparam int WDT_EN_LO = 5;
  localparam int WDT_CWS_LO = 8;
  localparam logic [4:0] WDT_CPS_MAX = 5'h12;
  localparam logic [1:0] WDT_OFF = 2'h0;
  localparam logic [2:0] WDT_CWS_OPEN = 3'h7;
  localparam int WDT_WIN_SH = 3;

  // power_control_status_reg bit positions and power-on value
  localparam int PC_STK_OVF = 7;
  localparam int PC_STK_UNF = 6;
  localparam int PC_WIN_VIOL_N = 5;
  localparam int PC_WDT_RST_N = 4;
  localparam int PC_XCLR_N = 3;
  localparam int PC_RST_INSTR_N = 2;
  localparam int PC_POR_N = 1;
  localparam int PC_BOR_N = 0;
  localparam logic [7:0] PCON_POR_VAL = 8'h3d;

  // power-up delay select encodings
  localparam logic [1:0] POWERUP_DELAY_SELECT_LONG = 2'h0;
  localparam logic [1:0] POWERUP_DELAY_SELECT_MID = 2'h1;
  localparam logic [1:0] POWERUP_DELAY_SELECT_SHORT = 2'h2;
  localparam logic [1:0] POWERUP_DELAY_SELECT_OFF = 2'h3;

  // timing, clock in MHz, times in microseconds
  localparam int CLK_MHZ = 100;
  localparam int POWERUP_DELAY_TIMER_LONG_US = 64000;
  localparam int POWERUP_DELAY_TIMER_MID_US = 16000;
  localparam int POWERUP_DELAY_TIMER_SHORT_US = 1000;
  localparam int WDT_BASE_US = 1000;
  localparam int POWERUP_DELAY_TIMER_LONG_CYC = POWERUP_DELAY_TIMER_LONG_US * CLK_MHZ;
  localparam int POWERUP_DELAY_TIMER_MID_CYC = POWERUP_DELAY_TIMER_MID_US * CLK_MHZ;
  localparam int POWERUP_DELAY_TIMER_SHORT_CYC = POWERUP_DELAY_TIMER_SHORT_US * CLK_MHZ;
  localparam int WDT_BASE_CYC = WDT_BASE_US * CLK_MHZ;

  // sequencer states, gray along reset -> delay -> run
  typedef enum logic [1:0] {
    rsc_st_rst  = 2'b00,
    rsc_st_powerup_delay_timer = 2'b01,
    rsc_st_run  = 2'b11
  } rsc_state_t;
endpackage

/* design/rsc_stk_if.sv */
`timescale 1ns/10ps
interface rsc_stk_if;
  import rsc_pkg::*;
  logic we;
  logic [SA_W-1:0] waddr;
  logic [STK_W-1:0] wdata;
  logic [SA_W-1:0] raddr;
  logic [STK_W-1:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* design/rsc_stack_mem.sv */
`timescale 1ns/10ps
module rsc_stack_mem
  import rsc_pkg::*;
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_arst_n,  // async reset, active low
  rsc_stk_if.mem stk          // stack access
);
  logic [STK_W-1:0] mem_q [STK_D];
  logic [STK_W-1:0] rdata_q;

  // storage has no reset: the pointer decides what is valid
  always_ff @(posedge i_clk_sys) begin
    if (stk.we) begin
      mem_q[stk.waddr] <= stk.wdata;
    end
  end

  // registered read of the current top entry
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[stk.raddr];
    end
  end

  assign stk.rdata = rdata_q;
endmodule

/* design/rsc_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - return-address stack holds 16 entries of 15 bits each
// - overflow or underflow sets its status flag; resets when enabled
// - stack faults reset the device only with the stack reset enable set
// - no internal reset source ever drives the external clear pin low
// - with external clear disabled the pin is input only, pull-up software owned
// - watchdog resets on missing clear before timeout or clear outside window
// - watchdog reset updates expiry, power-down and watchdog reset flags
// - window violation flag tells timeout apart from window violation
// - reset instruction resets the device and clears its flag to 0
// - leaving programming mode acts like a power-on reset but keeps the configuration words
// - optional power-up delay holds execution after brown-out or programming-mode exit
module rsc_top
  import rsc_pkg::*;
#(
  parameter int unsigned P_POWERUP_DELAY_TIMER_LONG_CYC = POWERUP_DELAY_TIMER_LONG_CYC,   // long power-up delay
  parameter int unsigned P_POWERUP_DELAY_TIMER_MID_CYC = POWERUP_DELAY_TIMER_MID_CYC,     // middle power-up delay
  parameter int unsigned P_POWERUP_DELAY_TIMER_SHORT_CYC = POWERUP_DELAY_TIMER_SHORT_CYC, // short power-up delay
  parameter int unsigned P_WDT_BASE_CYC = WDT_BASE_CYC      // watchdog base period
) (
  input wire logic i_clk_sys,                 // system clock, 100 MHz
  input wire logic i_arst_n,                  // power-on reset, active low
  input wire logic i_bor,                     // brown-out detect, async level
  input wire logic i_prog_mode,               // programming mode, async level
  input wire logic i_xclr_n,                  // external clear pin input
  output logic o_xclr_out,                    // external clear pin output value
  output logic o_xclr_oe,                     // external clear pin output enable
  output logic o_xclr_pu_en,                  // weak pull-up enable on clear pin
  output logic o_xclr_level,                  // filtered pin level for software
  input wire logic i_sw_pullup,               // software pull-up request
  input wire logic i_push,                    // call: push return address
  input wire logic i_pop,                     // return: pop address
  input wire logic [STK_W-1:0] i_push_addr,   // address to push
  output logic [STK_W-1:0] o_pop_addr,        // current top of stack
  input wire logic i_wdt_clear,               // watchdog clear instruction
  input wire logic i_reset_instr,             // reset instruction
  input wire logic i_pcon_we,                 // status register write strobe
  input wire logic [7:0] i_pcon_wdata,        // status register write data
  output logic [7:0] o_pcon_rdata,            // status register contents
  output logic o_to_n,                        // watchdog expiry flag, low active
  output logic o_pd_n,                        // power-down flag, low active
  input wire logic i_cfg_we,                  // configuration word write
  input wire logic [CFG_AW-1:0] i_cfg_addr,   // configuration word address
  input wire logic [CFG_DW-1:0] i_cfg_wdata,  // configuration word data
  output logic [CFG_DW-1:0] o_cfg_rdata,      // configuration read, one cycle
  output logic o_core_rst                     // core held in reset
);
  typedef struct packed {
    rsc_state_t st;
    logic pwr_evt;
    logic [31:0] powerup_delay_timer_cnt;
    logic [31:0] wdt_cnt;
    logic [SP_W-1:0] sp;
    logic [7:0] pcon;
    logic to_n;
    logic pd_n;
    logic [CFG_DW-1:0] cfg_sup;
    logic [CFG_DW-1:0] cfg_wdt;
    logic [CFG_DW-1:0] cfg_rd;
    logic [2:0] s_clr;
    logic [2:0] s_bor;
    logic [2:0] s_prog;
    logic f_clr;
    logic f_bor;
    logic f_prog;
  } rsc_q_t;

  localparam rsc_q_t Q_RST = '{
    st: rsc_st_rst, pwr_evt: 1'b1, powerup_delay_timer_cnt: '0, wdt_cnt: '0, sp: SP_EMPTY,
    pcon: PCON_POR_VAL, to_n: 1'b1, pd_n: 1'b1,
    cfg_sup: CFG_RST_VAL, cfg_wdt: CFG_RST_VAL, cfg_rd: '0,
    s_clr: 3'h7, s_bor: 3'h0, s_prog: 3'h0, f_clr: 1'b1, f_bor: 1'b0, f_prog: 1'b0
  };

  rsc_q_t q;
  rsc_q_t d;
  rsc_stk_if stk ();

  rsc_stack_mem u_stack (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .stk(stk)
  );

  // configuration fields steering the block
  logic xclr_en;
  logic stk_rst_en;
  logic [1:0] powerup_delay_select;
  logic wdt_en;
  logic [4:0] cps;
  logic [2:0] cws;
  assign xclr_en = q.cfg_sup[SUP_XCLR_EN];
  assign stk_rst_en = q.cfg_sup[SUP_STK_RST];
  assign powerup_delay_select = q.cfg_sup[SUP_POWERUP_DELAY_SELECT_LO +: 2];
  assign wdt_en = q.cfg_wdt[WDT_EN_LO +: 2] != WDT_OFF;
  assign cps = (q.cfg_wdt[WDT_CPS_LO +: 5] > WDT_CPS_MAX) ? WDT_CPS_MAX
                                                          : q.cfg_wdt[WDT_CPS_LO +: 5];
  assign cws = q.cfg_wdt[WDT_CWS_LO +: 3];

  // filtered pin events: second and third stage must agree
  logic bor_evt;
  logic prog_exit;
  logic xclr_hold;
  assign bor_evt = (q.s_bor[1] == q.s_bor[2]) && q.s_bor[2] && !q.f_bor;
  assign prog_exit = (q.s_prog[1] == q.s_prog[2]) && !q.s_prog[2] && q.f_prog;
  assign xclr_hold = xclr_en && !q.f_clr;

  // watchdog period and closed window, both in cycles
  logic [31:0] wdt_tmo;
  logic [31:0] wdt_thr;
  assign wdt_tmo = 32'(P_WDT_BASE_CYC) << cps;
  assign wdt_thr = (wdt_tmo >> WDT_WIN_SH) * 32'(WDT_CWS_OPEN - cws);

  // core-side events only count while running
  logic run;
  logic stk_ovf;
  logic stk_unf;
  logic push_ok;
  logic pop_ok;
  logic wdt_expire;
  logic wdt_viol;
  logic wdt_ok_clr;
  logic ri_evt;
  logic rst_req;
  logic pwr_any;
  assign run = q.st == rsc_st_run;
  assign stk_ovf = run && i_push && (q.sp == SP_FULL);
  assign stk_unf = run && i_pop && !i_push && (q.sp == SP_EMPTY);
  assign push_ok = run && i_push && (q.sp != SP_FULL);
  assign pop_ok = run && i_pop && !i_push && (q.sp != SP_EMPTY);
  assign wdt_viol = run && wdt_en && i_wdt_clear && (q.wdt_cnt < wdt_thr);
  assign wdt_expire = run && wdt_en && !i_wdt_clear
                      && (q.wdt_cnt >= wdt_tmo - 32'h1);
  assign wdt_ok_clr = run && i_wdt_clear && !wdt_viol;
  assign ri_evt = run && i_reset_instr;
  assign pwr_any = bor_evt || prog_exit;
  // stack faults only reset with the enable set
  assign rst_req = ((stk_ovf || stk_unf) && stk_rst_en) || wdt_expire
                   || wdt_viol || ri_evt || pwr_any || xclr_hold || q.f_prog;

  // stack memory port: write at pointer, read the entry below it
  assign stk.we = push_ok;
  assign stk.waddr = q.sp[SA_W-1:0];
  assign stk.wdata = i_push_addr;
  assign stk.raddr = q.sp[SA_W-1:0] - 4'h1;

  // power-up delay length from the select field
  logic [31:0] powerup_delay_timer_len;
  always_comb begin
    case (powerup_delay_select)
      POWERUP_DELAY_SELECT_LONG: powerup_delay_timer_len = 32'(P_POWERUP_DELAY_TIMER_LONG_CYC);
      POWERUP_DELAY_SELECT_MID: powerup_delay_timer_len = 32'(P_POWERUP_DELAY_TIMER_MID_CYC);
      POWERUP_DELAY_SELECT_SHORT: powerup_delay_timer_len = 32'(P_POWERUP_DELAY_TIMER_SHORT_CYC);
      default: powerup_delay_timer_len = 32'h1;
    endcase
  end

  // next state of the whole block
  always_comb begin
    d = q;
    // three-stage pin synchronisers and agreement filters
    d.s_clr = {q.s_clr[1:0], i_xclr_n};
    d.s_bor = {q.s_bor[1:0], i_bor};
    d.s_prog = {q.s_prog[1:0], i_prog_mode};
    if (q.s_clr[1] == q.s_clr[2]) begin
      d.f_clr = q.s_clr[2];
    end
    if (q.s_bor[1] == q.s_bor[2]) begin
      d.f_bor = q.s_bor[2];
    end
    if (q.s_prog[1] == q.s_prog[2]) begin
      d.f_prog = q.s_prog[2];
    end
    // configuration words are kept across every reset but power-on
    if (i_cfg_we && (i_cfg_addr == CFG_SUP_ADDR)) begin
      d.cfg_sup = i_cfg_wdata;
    end
    if (i_cfg_we && (i_cfg_addr == CFG_WDT_ADDR)) begin
      d.cfg_wdt = i_cfg_wdata;
    end
    d.cfg_rd = (i_cfg_addr == CFG_SUP_ADDR) ? q.cfg_sup :
               (i_cfg_addr == CFG_WDT_ADDR) ? q.cfg_wdt : '0;
    // software rewrite first, so a same-cycle hardware event wins
    if (i_pcon_we) begin
      d.pcon = i_pcon_wdata;
    end
    // stack pointer
    if (push_ok) begin
      d.sp = q.sp + SP_ONE;
    end else if (pop_ok) begin
      d.sp = q.sp - SP_ONE;
    end
    if (stk_ovf) begin
      d.pcon[PC_STK_OVF] = 1'b1;
    end
    if (stk_unf) begin
      d.pcon[PC_STK_UNF] = 1'b1;
    end
    // watchdog counter restarts on every accepted clear
    if (!run || wdt_ok_clr || !wdt_en) begin
      d.wdt_cnt = '0;
    end else begin
      d.wdt_cnt = q.wdt_cnt + 32'h1;
    end
    if (wdt_ok_clr) begin
      d.to_n = 1'b1;
      d.pd_n = 1'b1;
    end
    // watchdog reset marks expiry, awake and the cause
    if (wdt_expire || wdt_viol) begin
      d.to_n = 1'b0;
      d.pd_n = 1'b1;
      d.pcon[PC_WDT_RST_N] = 1'b0;
      d.pcon[PC_WIN_VIOL_N] = !wdt_viol;
    end
    if (ri_evt) begin
      d.pcon[PC_RST_INSTR_N] = 1'b0;
    end
    if (xclr_hold) begin
      d.pcon[PC_XCLR_N] = 1'b0;
    end
    if (bor_evt) begin
      d.pcon[PC_BOR_N] = 1'b0;
    end
    // leaving programming mode restores power-on flags
    if (prog_exit) begin
      d.pcon = PCON_POR_VAL;
      d.to_n = 1'b1;
      d.pd_n = 1'b1;
      d.cfg_sup = q.cfg_sup;
      d.cfg_wdt = q.cfg_wdt;
    end
    // sequencer; delay request survives a held reset
    d.pwr_evt = pwr_any || (q.pwr_evt && !run);
    case (q.st)
      rsc_st_run: begin
        if (rst_req) begin
          d.st = rsc_st_rst;
        end
      end
      rsc_st_rst: begin
        d.sp = SP_EMPTY;
        if (!rst_req) begin
          if (q.pwr_evt && (powerup_delay_select != POWERUP_DELAY_SELECT_OFF)) begin
            d.st = rsc_st_powerup_delay_timer;
            d.powerup_delay_timer_cnt = powerup_delay_timer_len - 32'h1;
          end else begin
            d.st = rsc_st_run;
          end
          d.pwr_evt = 1'b0;
        end
      end
      rsc_st_powerup_delay_timer: begin
        if (rst_req) begin
          d.st = rsc_st_rst;
        end else if (q.powerup_delay_timer_cnt == '0) begin
          d.st = rsc_st_run;
        end else begin
          d.powerup_delay_timer_cnt = q.powerup_delay_timer_cnt - 32'h1;
        end
      end
      default: begin
        d.st = rsc_st_rst;
      end
    endcase
  end

  // single state register; of the resets, only power-on and programming-mode exit restore the flags
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  // pin driver never pulls low, whatever resets the device
  assign o_xclr_out = 1'b0;
  assign o_xclr_oe = 1'b0;
  // pull-up forced on for clear use, else left to software
  assign o_xclr_pu_en = xclr_en ? 1'b1 : i_sw_pullup;
  assign o_xclr_level = q.f_clr;
  assign o_pop_addr = stk.rdata;
  assign o_pcon_rdata = q.pcon;
  assign o_to_n = q.to_n;
  assign o_pd_n = q.pd_n;
  assign o_cfg_rdata = q.cfg_rd;
  assign o_core_rst = !run;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  a_stk_depth: assert property (q.sp <= SP_FULL)
    else $error("stack pointer beyond depth");
  a_ovf_flag: assert property (stk_ovf |=> q.pcon[PC_STK_OVF])
    else $error("overflow flag not set");
  a_stk_rst_gate: assert property ((stk_ovf || stk_unf) && !stk_rst_en && !wdt_expire
    && !wdt_viol && !ri_evt && !pwr_any && !xclr_hold && !q.f_prog |=> run)
    else $error("stack fault reset without enable");
  a_pin_no_drive: assert property (!run |-> !o_xclr_oe && !o_xclr_out)
    else $error("clear pin driven during reset");
  a_pullup_owner: assert property (!xclr_en |-> o_xclr_pu_en == i_sw_pullup)
    else $error("pull-up not under software control");
  a_wdt_expire: assert property (wdt_expire |=> !run ##0 !o_to_n)
    else $error("watchdog expiry did not reset");
  a_wdt_flags: assert property (wdt_expire |=> !q.pcon[PC_WDT_RST_N] && q.pd_n)
    else $error("watchdog flags not updated");
  a_win_viol: assert property (wdt_viol |=> !q.pcon[PC_WIN_VIOL_N] && !run)
    else $error("window violation not recorded");
  a_rst_instr: assert property (ri_evt |=> !run && !q.pcon[PC_RST_INSTR_N])
    else $error("reset instruction not handled");
  a_prog_exit: assert property (prog_exit |=> q.pcon == PCON_POR_VAL ##1 !run)
    else $error("programming exit not like power-on");
  a_powerup_delay_timer_hold: assert property (q.st == rsc_st_powerup_delay_timer && q.powerup_delay_timer_cnt != '0
    && !rst_req |=> q.st == rsc_st_powerup_delay_timer && o_core_rst)
    else $error("power-up delay ended early");
  a_flag_keep: assert property (q.st == rsc_st_rst && !i_pcon_we && !pwr_any
    && !xclr_hold |=> $stable(q.pcon))
    else $error("cause flags lost across reset");

  c_wdt_expire: cover property (wdt_expire ##1 !run);
  c_stk_ovf: cover property (stk_ovf && stk_rst_en);
  c_powerup_delay_timer_run: cover property (q.st == rsc_st_powerup_delay_timer ##1 run);
  c_win_viol: cover property (wdt_viol);
endmodule

/* verification/rsc_pin_model.sv */
`timescale 1ns/10ps
// far side of the external clear pin: a switch to ground plus the wire itself
module rsc_pin_model (
  input wire logic i_clk_sys,  // system clock
  input wire logic i_oe,       // device output enable
  input wire logic i_out,      // device output value
  input wire logic i_pu_en,    // device weak pull-up
  input wire logic i_pull_low, // bench closes the switch to ground
  output logic o_pin           // resolved pin level
);
  logic float_q = 1'b0;
  // an undriven pin with no pull-up wanders, so show a toggling level there
  always_ff @(posedge i_clk_sys) begin
    float_q <= ~float_q;
  end
  // the switch wins, then the device driver, then the pull-up
  always_comb begin
    if (i_pull_low) begin
      o_pin = 1'b0;
    end else if (i_oe) begin
      o_pin = i_out;
    end else if (i_pu_en) begin
      o_pin = 1'b1;
    end else begin
      o_pin = float_q;
    end
  end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import rsc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_bor = 1'b0, i_prog_mode = 1'b0, i_sw_pullup = 1'b0, pull_low = 1'b0;
  logic i_push = 1'b0, i_pop = 1'b0, i_wdt_clear = 1'b0, i_reset_instr = 1'b0;
  logic [STK_W-1:0] i_push_addr = '0;
  logic i_pcon_we = 1'b0, i_cfg_we = 1'b0;
  logic [7:0] i_pcon_wdata = 8'h00;
  logic [CFG_AW-1:0] i_cfg_addr = '0;
  logic [CFG_DW-1:0] i_cfg_wdata = '0;
  logic pin, o_xclr_out, o_xclr_oe, o_xclr_pu_en, o_xclr_level, o_to_n, o_pd_n, o_core_rst;
  logic [STK_W-1:0] o_pop_addr;
  logic [7:0] o_pcon_rdata;
  logic [CFG_DW-1:0] o_cfg_rdata;
  int n_errors = 0;
  int n_compared = 0;
  int cnt;

  // 100 MHz system clock
  always #5 i_clk_sys = ~i_clk_sys;

  // short counts keep the run brief; expectations use the same values
  rsc_top #(.P_POWERUP_DELAY_TIMER_LONG_CYC(8), .P_POWERUP_DELAY_TIMER_MID_CYC(4), .P_POWERUP_DELAY_TIMER_SHORT_CYC(2),
    .P_WDT_BASE_CYC(16)) i_dut (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_bor(i_bor), .i_prog_mode(i_prog_mode),
    .i_xclr_n(pin), .o_xclr_out(o_xclr_out), .o_xclr_oe(o_xclr_oe),
    .o_xclr_pu_en(o_xclr_pu_en), .o_xclr_level(o_xclr_level), .i_sw_pullup(i_sw_pullup),
    .i_push(i_push), .i_pop(i_pop), .i_push_addr(i_push_addr), .o_pop_addr(o_pop_addr),
    .i_wdt_clear(i_wdt_clear), .i_reset_instr(i_reset_instr), .i_pcon_we(i_pcon_we),
    .i_pcon_wdata(i_pcon_wdata), .o_pcon_rdata(o_pcon_rdata), .o_to_n(o_to_n),
    .o_pd_n(o_pd_n), .i_cfg_we(i_cfg_we), .i_cfg_addr(i_cfg_addr),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .o_core_rst(o_core_rst));

  rsc_pin_model i_pin (.i_clk_sys(i_clk_sys), .i_oe(o_xclr_oe), .i_out(o_xclr_out),
    .i_pu_en(o_xclr_pu_en), .i_pull_low(pull_low), .o_pin(pin));

  task report_and_stop();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // bounded wait for the core reset level
  task wait_rst(input logic v, input int max);
    cnt = 0;
    while (o_core_rst !== v && cnt < max) begin
      tick(1);
      cnt++;
    end
    check(o_core_rst, v);
  endtask

  // one-cycle core pulse: 0 push, 1 pop, 2 watchdog clear, 3 reset instruction
  task core_op(input int op, input logic [STK_W-1:0] a);
    i_push = (op == 0);
    i_pop = (op == 1);
    i_wdt_clear = (op == 2);
    i_reset_instr = (op == 3);
    i_push_addr = a;
    tick(1);
    {i_push, i_pop, i_wdt_clear, i_reset_instr} = 4'h0;
  endtask

  task cfg_wr(input logic [CFG_AW-1:0] a, input logic [CFG_DW-1:0] d);
    i_cfg_we = 1'b1;
    i_cfg_addr = a;
    i_cfg_wdata = d;
    tick(1);
    i_cfg_we = 1'b0;
  endtask

  task cfg_rd(input logic [CFG_AW-1:0] a, input logic [CFG_DW-1:0] exp);
    i_cfg_addr = a;
    tick(1);
    check(o_cfg_rdata, exp);
  endtask

  // write the status register and read it back
  task pcon_wr(input logic [7:0] d);
    i_pcon_we = 1'b1;
    i_pcon_wdata = d;
    tick(1);
    i_pcon_we = 1'b0;
    tick(1);
    check(o_pcon_rdata, d);
  endtask

  // watchdog: a hung test must still end the run through the same door
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  // brown-out with a chosen delay: one reset cycle plus the delay length
  task bor_run(input logic [CFG_DW-1:0] c, input int exp);
    cfg_wr(CFG_SUP_ADDR, c);
    i_bor = 1'b1;
    wait_rst(1'b1, 10);
    i_bor = 1'b0;
    cnt = 0;
    while (o_core_rst === 1'b1 && cnt < 40) begin
      tick(1);
      cnt++;
    end
    check(16'(cnt), 16'(exp));
    check(o_pcon_rdata[PC_BOR_N], 1'b0);
  endtask

  initial begin
    tick(12);
    check(o_pcon_rdata, PCON_POR_VAL);
    check({o_to_n, o_pd_n, o_core_rst, o_xclr_oe}, 4'he);
    i_arst_n = 1'b1;
    wait_rst(1'b0, 20);
    cfg_rd(CFG_SUP_ADDR, CFG_RST_VAL);
    cfg_rd(CFG_WDT_ADDR, CFG_RST_VAL);
    cfg_rd(16'h8007, 14'h0000);
    // stack reset off, clear pin off, no power-up delay
    cfg_wr(CFG_SUP_ADDR, 14'h2ffe);
    cfg_rd(CFG_SUP_ADDR, 14'h2ffe);
    for (int i = 0; i < STK_D; i++) begin
      core_op(0, 15'h7f00 + 15'(i));
      tick(1);
      check(o_pop_addr, 15'h7f00 + 15'(i));
    end
    core_op(0, 15'h1234);
    tick(2);
    check(o_pcon_rdata[PC_STK_OVF], 1'b1);
    check(o_core_rst, 1'b0);
    for (int i = 0; i < STK_D - 1; i++) begin
      core_op(1, '0);
      tick(1);
      check(o_pop_addr, 15'h7f0e - 15'(i));
    end
    core_op(1, '0);
    // let an edge pass so the pop strobe is not lowered and raised at once
    tick(1);
    core_op(1, '0);
    tick(2);
    check(o_pcon_rdata[PC_STK_UNF], 1'b1);
    check(o_core_rst, 1'b0);
    pcon_wr(8'h3d);
    // stack fault now resets, and its flag survives that reset
    cfg_wr(CFG_SUP_ADDR, 14'h3ffe);
    core_op(1, '0);
    wait_rst(1'b1, 3);
    check({o_xclr_oe, o_xclr_out}, 2'h0);
    wait_rst(1'b0, 10);
    check(o_pcon_rdata[PC_STK_UNF], 1'b1);
    // clear pin disabled: input only, pull-up in software hands
    check(o_xclr_pu_en, 1'b0);
    i_sw_pullup = 1'b1;
    tick(1);
    check(o_xclr_pu_en, 1'b1);
    pull_low = 1'b1;
    tick(8);
    check({o_core_rst, o_xclr_level, o_xclr_oe}, 3'h0);
    // keep the pull-up on so the filter sees a high pin before enabling
    pull_low = 1'b0;
    tick(6);
    check({o_xclr_level, o_pcon_rdata[PC_XCLR_N]}, 2'h3);
    // clear pin enabled: low level holds reset
    cfg_wr(CFG_SUP_ADDR, 14'h3fff);
    i_sw_pullup = 1'b0;
    tick(6);
    check({o_xclr_pu_en, o_core_rst}, 2'h2);
    pull_low = 1'b1;
    wait_rst(1'b1, 10);
    check({o_pcon_rdata[PC_XCLR_N], o_xclr_oe, o_xclr_out}, 3'h0);
    pull_low = 1'b0;
    wait_rst(1'b0, 10);
    // reset instruction
    core_op(3, '0);
    wait_rst(1'b1, 3);
    check({o_pcon_rdata[PC_RST_INSTR_N], o_xclr_oe}, 2'h0);
    wait_rst(1'b0, 10);
    pcon_wr(8'h3f);
    // watchdog with a 16-cycle timeout and an open window
    cfg_wr(CFG_WDT_ADDR, 14'h3fe0);
    for (int i = 0; i < 5; i++) begin
      tick(10);
      core_op(2, '0);
    end
    check(o_core_rst, 1'b0);
    wait_rst(1'b1, 30);
    check({o_to_n, o_pd_n, o_pcon_rdata[PC_WDT_RST_N], o_pcon_rdata[PC_WIN_VIOL_N]},
      4'h5);
    // closed window: an early clear is a violation
    cfg_wr(CFG_WDT_ADDR, 14'h38e0);
    wait_rst(1'b0, 5);
    core_op(2, '0);
    wait_rst(1'b1, 3);
    check({o_to_n, o_pcon_rdata[PC_WDT_RST_N], o_pcon_rdata[PC_WIN_VIOL_N]}, 3'h0);
    cfg_wr(CFG_WDT_ADDR, 14'h3f80);
    wait_rst(1'b0, 5);
    // brown-out with the long, then the middle power-up delay
    bor_run(14'h3ff9, 9);
    pcon_wr(8'h3f);
    bor_run(14'h3ffb, 5);
    // programming mode exit acts as power-on, short delay selected
    cfg_wr(CFG_SUP_ADDR, 14'h3ffd);
    i_prog_mode = 1'b1;
    wait_rst(1'b1, 10);
    tick(10);
    check(o_core_rst, 1'b1);
    i_prog_mode = 1'b0;
    wait_rst(1'b0, 40);
    check({o_to_n, o_pd_n}, 2'h3);
    check(o_pcon_rdata, PCON_POR_VAL);
    report_and_stop();
  end
endmodule
